//--- rtl/cid_pkg.sv
/*
 Shared constants and types of the caller-identity receiver control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cid_pkg;
	// Function select pair {select_a, select_b}
	localparam logic [1:0] FSEL_FSK     = 2'h3;
	localparam logic [1:0] FSEL_OFFHOOK = 2'h2;
	localparam logic [1:0] FSEL_ONHOOK  = 2'h1;
	localparam logic [1:0] FSEL_NONE    = 2'h0;
	localparam logic       MODE_STREAM  = 1'h0;
	localparam logic       MODE_BUFFER  = 1'h1;

	localparam int         DATA_BITS    = 8;
	localparam int         FRAME_W      = 9;
	localparam int         CNT_W        = 4;
	localparam logic [3:0] LAST_DATA    = 4'h7;
	localparam logic [3:0] LINK_LAST    = 4'h8;
	localparam int         STOP_POS     = 8;
	localparam logic       START_LVL    = 1'h0;
	localparam logic       IDLE_LVL     = 1'h1;
	localparam int         SYNC_W       = 3;
	localparam int         BUF_DEPTH    = 2;

	typedef enum logic [1:0] {
		FR_IDLE = 2'b00,
		FR_DATA = 2'b01,
		FR_STOP = 2'b10
	} cid_frame_t;
endpackage

//--- rtl/cid_sync.sv
/*
 Three-stage synchroniser, one per bit; the output moves only when
 stages two and three agree. Assumes asynchronous inputs.
*/
`timescale 1ns/10ps
module cid_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,     // Destination clock
	input  wire logic         reset_n_i, // Async reset, active low
	input  wire logic         ce_i,      // Clock enable
	input  wire logic [W-1:0] d_i,       // Asynchronous input
	output logic      [W-1:0] q_o        // Settled value
);
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic s1_reg, s2_reg, s3_reg, q_reg, q_next;
			always_comb begin
				q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
			end
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					s1_reg <= 1'h0;
					s2_reg <= 1'h0;
					s3_reg <= 1'h0;
					q_reg  <= 1'h0;
				end else if (ce_i) begin
					s1_reg <= d_i[g];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					q_reg  <= q_next;
				end
			end
			assign q_o[g] = q_reg;
		end
	endgenerate
endmodule // cid_sync

//--- rtl/cid_buf2.sv
/*
 Two-entry word buffer with valid/ready on both sides.
 Assumes one clock; ce freezes it.
*/
`timescale 1ns/10ps
module cid_buf2
	import cid_pkg::*;
(
	input  wire logic               clk_i,     // Clock
	input  wire logic               reset_n_i, // Async reset, active low
	input  wire logic               ce_i,      // Clock enable
	input  wire logic               in_valid_i,// Word offered
	output logic                    in_ready_o,// Room for a word
	input  wire logic [FRAME_W-1:0] in_data_i, // Word in
	output logic                    out_valid_o,// Word available
	input  wire logic               out_ready_i,// Sink takes word
	output logic      [FRAME_W-1:0] out_data_o // Word out
);
	logic [FRAME_W-1:0] mem_reg [BUF_DEPTH];
	logic               wr_reg, wr_next, rd_reg, rd_next;
	logic [1:0]         cnt_reg, cnt_next;
	logic               push, pop;

	always_comb begin
		push       = in_valid_i && (cnt_reg != 2'(BUF_DEPTH)) && ce_i;
		pop        = out_ready_i && (cnt_reg != 2'h0) && ce_i;
		wr_next    = push ? ~wr_reg : wr_reg;
		rd_next    = pop ? ~rd_reg : rd_reg;
		cnt_next   = cnt_reg + {1'h0, push} - {1'h0, pop};
		in_ready_o = (cnt_reg != 2'(BUF_DEPTH));
		out_valid_o = (cnt_reg != 2'h0);
		out_data_o = mem_reg[rd_reg];
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_reg  <= 1'h0;
			rd_reg  <= 1'h0;
			cnt_reg <= 2'h0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage has no reset; guarded by the count
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data_i;
		end
	end
endmodule // cid_buf2

//--- rtl/cid_mode_ctrl.sv
/*
 Mode and data-output control of the caller-identity receiver: function
 decode, power-down enables, byte framing, raw stream strobes and the
 host-clocked one-byte shift-out. Assumes the demodulator and tone
 detector run on mclk_i; select pins and the shift clock come from the host.
*/
`timescale 1ns/10ps
// What this block does
// - FSK demodulates only the line-side input
// - On-hook tone: line side; off-hook: handset side
// - Raw bit stream or shift buffer: one held word plus two queued
// - Buffer keeps stop bit after eight data
// - Stream gives bit strobe and byte-end strobe
// - Carrier status; no carrier suppresses data
// - Both 1200 baud formats, no host selection
// - Full power down stops amps, detectors, oscillator
// - FSK selected keeps tone detector off
// - Tone selected keeps FSK demodulator off
// - Amplifiers stay on in partial power down
// - Select pins: 11 FSK, 10 off-hook, 01 on-hook
// - Shared output: byte ready or tone detected
// - Mode high, selects low: power down, output high
// - Mode pin picks stream/buffer; buffer: clock input
module cid_mode_ctrl
	import cid_pkg::*;
(
	input  wire logic mclk_i,                // System clock, 200 MHz
	input  wire logic reset_n_i,             // Async reset, active low
	input  wire logic ce_i,                  // Clock enable
	input  wire logic interface_mode_select_i, // Pin: 0 stream, 1 buffer
	input  wire logic function_select_a_i,   // Pin: function select a
	input  wire logic function_select_b_i,   // Pin: function select b
	input  wire logic data_shift_clock_i,    // Host shift clock (link)
	input  wire logic demod_bit_i,           // Demodulated bit
	input  wire logic demod_bit_valid_i,     // Bit sampling instant
	input  wire logic demod_carrier_i,       // Carrier present
	input  wire logic tone_detect_i,         // Alerting tone seen
	output logic      line_amp_en_o,         // Line-side amplifier on
	output logic      handset_amp_en_o,      // Handset-side amplifier on
	output logic      fsk_demod_en_o,        // FSK demodulator on
	output logic      fsk_src_line_o,        // FSK fed from line side
	output logic      tone_en_o,             // Tone detector on
	output logic      tone_algo_offhook_o,   // 1 off-hook, 0 on-hook
	output logic      tone_src_handset_o,    // Tone fed from handset side
	output logic      osc_en_o,              // Oscillator on
	output logic      carrier_detect_o,      // Carrier status
	output logic      shared_ready_detect_n_o, // Ready/detect, active low
	output logic      stream_data_o,         // Raw bit stream
	output logic      bit_strobe_o,          // Stream bit strobe
	output logic      byte_end_strobe_o,     // Stream byte end
	output logic      data_shift_clock_out_o,            // Shift clock pin out
	output logic      data_shift_clock_oe_n_o,           // Shift clock drive, low=on
	output logic      shift_data_o           // Buffered serial data
);
	logic [2:0]   pins_q;
	logic         mode_q;
	logic [1:0]   fsel_q;
	logic         ack_q;

	cid_sync #(.W(SYNC_W)) u_pin_sync (
		.clk_i     (mclk_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.d_i       ({interface_mode_select_i, function_select_a_i,
		              function_select_b_i}),
		.q_o       (pins_q)
	);
	assign mode_q = pins_q[2];
	assign fsel_q = pins_q[1:0];

	function automatic logic is_pd(input logic m, input logic [1:0] f);
		return (m == MODE_BUFFER) && (f == FSEL_NONE);
	endfunction
	function automatic logic is_tone(input logic [1:0] f);
		return (f == FSEL_OFFHOOK) || (f == FSEL_ONHOOK);
	endfunction

	// Power and routing
	logic line_amp_reg, line_amp_next, hs_amp_reg, hs_amp_next;
	logic fsk_reg, fsk_next, tone_reg, tone_next, off_reg, off_next;
	logic osc_reg, osc_next, pd_reg, pd_next;

	always_comb begin
		pd_next       = is_pd(mode_q, fsel_q);
		fsk_next      = (fsel_q == FSEL_FSK);
		tone_next     = is_tone(fsel_q);
		off_next      = (fsel_q == FSEL_OFFHOOK);
		// Amps follow function, not partial power down
		line_amp_next = fsk_next || tone_next;
		hs_amp_next   = fsk_next || tone_next;
		osc_next      = !pd_next;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pd_reg       <= 1'h0;
			fsk_reg      <= 1'h0;
			tone_reg     <= 1'h0;
			off_reg      <= 1'h0;
			line_amp_reg <= 1'h0;
			hs_amp_reg   <= 1'h0;
			osc_reg      <= 1'h1;
		end else if (ce_i) begin
			pd_reg       <= pd_next;
			fsk_reg      <= fsk_next;
			tone_reg     <= tone_next;
			off_reg      <= off_next;
			line_amp_reg <= line_amp_next;
			hs_amp_reg   <= hs_amp_next;
			osc_reg      <= osc_next;
		end
	end

	assign line_amp_en_o       = line_amp_reg;
	assign handset_amp_en_o    = hs_amp_reg;
	assign fsk_demod_en_o      = fsk_reg;
	assign fsk_src_line_o      = fsk_reg;
	assign tone_en_o           = tone_reg;
	assign tone_algo_offhook_o = off_reg;
	assign tone_src_handset_o  = off_reg;
	assign osc_en_o            = osc_reg;

	// Byte framing
	cid_frame_t           fr_reg, fr_next;
	logic [CNT_W-1:0]     bit_cnt_reg, bit_cnt_next;
	logic [DATA_BITS-1:0] sh_reg, sh_next;
	logic                 bit_ok, buf_in_valid, buf_in_ready;
	logic [FRAME_W-1:0]   buf_in_data;

	always_comb begin
		bit_ok       = demod_bit_valid_i && demod_carrier_i && fsk_reg;
		fr_next      = fr_reg;
		bit_cnt_next = bit_cnt_reg;
		sh_next      = sh_reg;
		buf_in_valid = 1'h0;
		buf_in_data  = {demod_bit_i, sh_reg};
		unique case (fr_reg)
			FR_IDLE: begin
				if (bit_ok && demod_bit_i == START_LVL) begin
					fr_next      = FR_DATA;
					bit_cnt_next = '0;
				end
			end
			FR_DATA: begin
				if (bit_ok) begin
					sh_next      = {demod_bit_i, sh_reg[DATA_BITS-1:1]};
					bit_cnt_next = bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == LAST_DATA) begin
						fr_next = FR_STOP;
					end
				end
			end
			FR_STOP: begin
				if (bit_ok) begin
					// Full buffer stalls here; later bits are lost
					buf_in_valid = (mode_q == MODE_BUFFER);
					if (buf_in_ready || mode_q == MODE_STREAM) begin
						fr_next = FR_IDLE;
					end
				end
			end
			default: fr_next = FR_IDLE;
		endcase
		if (!demod_carrier_i || !fsk_reg) begin
			fr_next = FR_IDLE;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fr_reg      <= FR_IDLE;
			bit_cnt_reg <= '0;
			sh_reg      <= '0;
		end else if (ce_i) begin
			fr_reg      <= fr_next;
			bit_cnt_reg <= bit_cnt_next;
			sh_reg      <= sh_next;
		end
	end

	// Handoff to the host clock
	logic               buf_out_valid, buf_out_ready;
	logic [FRAME_W-1:0] buf_out_data;
	logic [FRAME_W-1:0] hold_reg, hold_next;
	logic               busy_reg, busy_next;
	logic               ack_prev_reg, ack_prev_next;

	cid_buf2 u_buf (
		.clk_i       (mclk_i),
		.reset_n_i   (reset_n_i),
		.ce_i        (ce_i),
		.in_valid_i  (buf_in_valid),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (buf_in_data),
		.out_valid_o (buf_out_valid),
		.out_ready_i (buf_out_ready),
		.out_data_o  (buf_out_data)
	);

	always_comb begin
		ack_prev_next = ack_q;
		buf_out_ready = !busy_reg;
		hold_next     = hold_reg;
		busy_next     = busy_reg;
		if (busy_reg && ack_q != ack_prev_reg) begin
			busy_next = 1'h0;
		end else if (!busy_reg && buf_out_valid) begin
			// Word stays still while the host shifts it
			hold_next = buf_out_data;
			busy_next = 1'h1;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hold_reg     <= '0;
			busy_reg     <= 1'h0;
			ack_prev_reg <= 1'h0;
		end else if (ce_i) begin
			hold_reg     <= hold_next;
			busy_reg     <= busy_next;
			ack_prev_reg <= ack_prev_next;
		end
	end

	// Link domain: host shift clock
	logic [CNT_W-1:0] lk_cnt_reg, lk_cnt_next;
	logic             lk_ack_reg, lk_ack_next, lk_dat_reg, lk_dat_next;

	always_comb begin
		lk_dat_next = lk_dat_reg;
		lk_cnt_next = lk_cnt_reg;
		lk_ack_next = lk_ack_reg;
		// Edges with no word held are the pin echoing its own stream strobe
		if (busy_reg) begin
			// Host gives exactly nine edges; busy and hold stay still meanwhile
			lk_dat_next = hold_reg[lk_cnt_reg];
			lk_cnt_next = lk_cnt_reg + 4'h1;
			if (lk_cnt_reg == LINK_LAST) begin
				lk_cnt_next = '0;
				lk_ack_next = ~lk_ack_reg;
			end
		end
	end

	always_ff @(posedge data_shift_clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lk_cnt_reg <= '0;
			lk_ack_reg <= 1'h0;
			lk_dat_reg <= 1'h0;
		end else begin
			lk_cnt_reg <= lk_cnt_next;
			lk_ack_reg <= lk_ack_next;
			lk_dat_reg <= lk_dat_next;
		end
	end
	assign shift_data_o = lk_dat_reg;

	cid_sync #(.W(1)) u_ack_sync (
		.clk_i     (mclk_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.d_i       (lk_ack_reg),
		.q_o       (ack_q)
	);

	// Pin outputs
	logic car_reg, car_next, sd_reg, sd_next, bs_reg, bs_next;
	logic be_reg, be_next, rd_n_reg, rd_n_next, oe_n_reg, oe_n_next;
	logic stream_sel;

	always_comb begin
		stream_sel = fsk_reg && (mode_q == MODE_STREAM);
		car_next   = demod_carrier_i && fsk_reg;
		sd_next    = (stream_sel && demod_carrier_i) ? demod_bit_i : IDLE_LVL;
		bs_next    = stream_sel && bit_ok && (fr_reg == FR_DATA);
		be_next    = stream_sel && bit_ok && (fr_reg == FR_STOP);
		oe_n_next  = (mode_q == MODE_BUFFER);
		if (pd_reg) begin
			rd_n_next = 1'h1;
		end else if (tone_reg) begin
			rd_n_next = !tone_detect_i;
		end else if (fsk_reg && mode_q == MODE_BUFFER) begin
			rd_n_next = !busy_reg;
		end else if (fsk_reg) begin
			rd_n_next = !be_next;
		end else begin
			rd_n_next = 1'h1;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			car_reg  <= 1'h0;
			sd_reg   <= 1'h1;
			bs_reg   <= 1'h0;
			be_reg   <= 1'h0;
			rd_n_reg <= 1'h1;
			oe_n_reg <= 1'h1;
		end else if (ce_i) begin
			car_reg  <= car_next;
			sd_reg   <= sd_next;
			bs_reg   <= bs_next;
			be_reg   <= be_next;
			rd_n_reg <= rd_n_next;
			oe_n_reg <= oe_n_next;
		end
	end

	assign carrier_detect_o        = car_reg;
	assign stream_data_o           = sd_reg;
	assign bit_strobe_o            = bs_reg;
	assign byte_end_strobe_o       = be_reg;
	assign data_shift_clock_out_o              = bs_reg;
	assign data_shift_clock_oe_n_o             = oe_n_reg;
	assign shared_ready_detect_n_o = rd_n_reg;

	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_pd_sel;
		ce_i && is_pd(mode_q, fsel_q);
	endsequence
	sequence s_stop_bit;
		ce_i && stream_sel && bit_ok && fr_reg == FR_STOP;
	endsequence

	pd_all_off_a: assert property (s_pd_sel |=> !osc_en_o && !line_amp_en_o
		&& !handset_amp_en_o && !fsk_demod_en_o && !tone_en_o)
		else $error("power down left a unit on");
	pd_ready_high_a: assert property (s_pd_sel ##1 ce_i |=> shared_ready_detect_n_o)
		else $error("ready/detect low in power down");
	fsk_no_tone_a: assert property (fsk_demod_en_o |-> !tone_en_o && fsk_src_line_o)
		else $error("tone detector on with FSK");
	tone_no_fsk_a: assert property (tone_en_o |-> !fsk_demod_en_o)
		else $error("FSK on with tone detection");
	tone_route_a: assert property ((ce_i && fsel_q == FSEL_OFFHOOK) |=>
		tone_en_o && tone_src_handset_o && tone_algo_offhook_o)
		else $error("off-hook tone on wrong input");
	amps_on_a: assert property ((fsk_demod_en_o || tone_en_o) |->
		line_amp_en_o && handset_amp_en_o)
		else $error("amplifier off in partial power down");
	carrier_gate_a: assert property ((ce_i && !demod_carrier_i) |=>
		stream_data_o == IDLE_LVL && !bit_strobe_o)
		else $error("data passed without carrier");
	byte_end_a: assert property (s_stop_bit |=> byte_end_strobe_o
		&& !shared_ready_detect_n_o)
		else $error("byte end strobe missing");
	ready_busy_a: assert property ((ce_i && fsk_reg && !pd_reg
		&& mode_q == MODE_BUFFER && busy_reg) |=> !shared_ready_detect_n_o)
		else $error("byte ready not shown");
	data_shift_clock_dir_a: assert property ((ce_i && mode_q == MODE_BUFFER) |=> data_shift_clock_oe_n_o)
		else $error("shift clock driven in buffer mode");
endmodule // cid_mode_ctrl

//--- tb/cid_host_model.sv
/*
 Host side of the shift-out link: owns the shift clock pin when the
 design lets go of it and reads buffered words bit by bit.
 Assumes the design drives the pin only while its enable is low.
*/
`timescale 1ns/10ps
module cid_host_model (
	input  wire logic data_shift_clock_out_i,   // Design drive of shift clock
	input  wire logic data_shift_clock_oe_n_i,  // Design drive enable, low=on
	input  wire logic shift_data_i, // Buffered serial data
	output logic      data_shift_clock_pin_o    // Resolved shift clock pin
);
	logic host_clk;

	// Host drives the pin only when the design has released it
	assign data_shift_clock_pin_o = data_shift_clock_oe_n_i ? host_clk : data_shift_clock_out_i;

	initial host_clk = 1'h0;

	// Clock idles low between words; gap models a slow host
	task automatic read_word(input int gap, output logic [8:0] w);
		#(gap);
		for (int k = 0; k < 9; k++) begin
			#7.5 host_clk = 1'h1;
			#7.5 w[k] = shift_data_i;
			host_clk = 1'h0;
		end
	endtask
endmodule // cid_host_model

//--- tb/test_cid_mode_ctrl.sv
/*
 Self-checking bench of the mode control block with a host model on
 the shift link. Assumes the package constants and a 200 MHz mclk.
*/
`timescale 1ns/10ps
module test_cid_mode_ctrl
	import cid_pkg::*;
;
	logic       mclk_i, reset_n_i, mode, sel_a, sel_b, dbit, dvalid, carrier, tone;
	logic       line_amp, hs_amp, fsk_en, src_line, tone_en, offhook, src_hs, osc_en;
	logic       carrier_det, rdy_n, sdata, bstr, bestr, data_shift_clock_out, data_shift_clock_oe_n, shdata;
	wire  logic data_shift_clock_pin;
	int         errors, checks_done;
	logic [8:0] w;
	logic [7:0] d0, d1, m;
	logic [1:0] f;

	cid_mode_ctrl cid_mode_ctrl_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(1'h1),
		.interface_mode_select_i(mode), .function_select_a_i(sel_a),
		.function_select_b_i(sel_b), .data_shift_clock_i(data_shift_clock_pin), .demod_bit_i(dbit),
		.demod_bit_valid_i(dvalid), .demod_carrier_i(carrier), .tone_detect_i(tone),
		.line_amp_en_o(line_amp), .handset_amp_en_o(hs_amp), .fsk_demod_en_o(fsk_en),
		.fsk_src_line_o(src_line), .tone_en_o(tone_en), .tone_algo_offhook_o(offhook),
		.tone_src_handset_o(src_hs), .osc_en_o(osc_en), .carrier_detect_o(carrier_det),
		.shared_ready_detect_n_o(rdy_n), .stream_data_o(sdata), .bit_strobe_o(bstr),
		.byte_end_strobe_o(bestr), .data_shift_clock_out_o(data_shift_clock_out), .data_shift_clock_oe_n_o(data_shift_clock_oe_n),
		.shift_data_o(shdata));

	cid_host_model cid_host_model_i (.data_shift_clock_out_i(data_shift_clock_out), .data_shift_clock_oe_n_i(data_shift_clock_oe_n),
		.shift_data_i(shdata), .data_shift_clock_pin_o(data_shift_clock_pin));

	initial begin
		mclk_i = 1'h0;
		forever #2.5 mclk_i = ~mclk_i;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("Error: %s expected %h seen %h", what, exp, got);
			errors++;
		end
	endtask

	task automatic print_verdict();
		if (errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wait_rdy(input logic lvl);
		int n;
		n = 0;
		while (rdy_n !== lvl && n < 60) begin
			tick(1);
			n++;
		end
		if (rdy_n !== lvl) begin
			$display("Error: ready/detect expected %b seen %b", lvl, rdy_n);
			errors++;
			print_verdict();
		end
	endtask

	// {mask, expected} over line, handset, fsk, src_line, tone, offhook, src_hs, osc
	function automatic logic [15:0] exp_en(input logic md, input logic [1:0] fs);
		case (fs)
			FSEL_FSK:     return 16'hFFF1;
			FSEL_OFFHOOK: return 16'hFFCF;
			FSEL_ONHOOK:  return 16'hFFC9;
			default:      return md ? 16'hFF00 : 16'hFF01;
		endcase
	endfunction

	task automatic set_pins(input logic md, input logic [1:0] fs);
		logic [15:0] e;
		mode = md;
		{sel_a, sel_b} = fs;
		tick(8); // Sync plus output register, with margin
		e = exp_en(md, fs);
		chk("enables", {1'h0, e[7:0]}, {1'h0, e[15:8] &
			{line_amp, hs_amp, fsk_en, src_line, tone_en, offhook, src_hs, osc_en}});
		chk("shift clock drive off", {8'h0, md}, {8'h0, data_shift_clock_oe_n});
	endtask

	// Start, eight data LSB first, stop; strobes appear only in stream form
	task automatic send_frame(input logic [7:0] d, input logic md);
		logic [9:0] fr;
		logic       bs, be, rl, dk;
		fr = {1'h1, d, 1'h0};
		for (int i = 0; i < 10; i++) begin
			dbit = fr[i];
			dvalid = 1'h1;
			tick(1);
			dvalid = 1'h0;
			// Strobes stand only in the cycle right after the valid edge
			{bs, be, rl, dk} = {bstr, bestr, !rdy_n, data_shift_clock_out};
			repeat (3) begin
				tick(1);
				bs |= bstr;
				be |= bestr;
				rl |= !rdy_n;
				dk |= data_shift_clock_out;
			end
			chk("bit strobe", {8'h0, !md && i > 0 && i < 9}, {8'h0, bs});
			chk("shift clock out", {8'h0, !md && i > 0 && i < 9}, {8'h0, dk});
			chk("byte end strobe", {8'h0, !md && i == 9}, {8'h0, be});
			if (!md && i > 0 && i < 9)
				chk("stream data", {8'h0, fr[i]}, {8'h0, sdata});
			if (!md && i == 9)
				chk("byte ready", 9'h1, {8'h0, rl});
		end
	endtask

	initial begin
		{mode, sel_a, sel_b, dbit, dvalid, carrier, tone} = 7'h0;
		errors = 0;
		checks_done = 0;
		reset_n_i = 1'h0;
		void'($urandom(76024));
		tick(6);
		reset_n_i = 1'h1;
		// Every function in both interface forms, plus power down
		for (int i = 0; i < 8; i++) begin
			f = i[1:0];
			set_pins(i[2], f);
			if (f == FSEL_NONE)
				chk("power down output", 9'h1, {8'h0, rdy_n});
			if (f == FSEL_OFFHOOK || f == FSEL_ONHOOK) begin
				repeat (4) begin
					tone = 1'($urandom);
					carrier = 1'($urandom);
					tick(3);
					chk("tone detected", {8'h0, !tone}, {8'h0, rdy_n});
					chk("carrier in tone", 9'h0, {8'h0, carrier_det});
				end
			end
		end
		tone = 1'h0;
		// Stream form: corner bytes then random ones, formats need no selection
		set_pins(1'h0, FSEL_FSK);
		carrier = 1'h1;
		tick(4);
		chk("carrier status", 9'h1, {8'h0, carrier_det});
		send_frame(8'h00, 1'h0);
		send_frame(8'hFF, 1'h0);
		repeat (3) send_frame(8'($urandom), 1'h0);
		carrier = 1'h0;
		tick(4);
		chk("carrier gone", 9'h0, {8'h0, carrier_det});
		chk("suppressed data", 9'h1, {8'h0, sdata});
		dbit = 1'h0;
		dvalid = 1'h1;
		tick(1);
		dvalid = 1'h0;
		chk("no strobe", 9'h0, {8'h0, bstr | bestr});
		tick(3);
		// Buffer form: hold one word and queue a second while the host stalls, then drain
		set_pins(1'h1, FSEL_FSK);
		carrier = 1'h1;
		tick(4);
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		send_frame(d0, 1'h1);
		send_frame(d1, 1'h1);
		for (int j = 0; j < 2; j++) begin
			wait_rdy(1'h0);
			cid_host_model_i.read_word($urandom_range(60), w);
			m = j ? d1 : d0;
			chk("buffered word", {1'h1, m}, w);
			wait_rdy(1'h1);
		end
		tick(12);
		chk("buffer empty", 9'h1, {8'h0, rdy_n});
		print_verdict();
	end
endmodule // test_cid_mode_ctrl
